/* File: bridge_pkg.sv */
package bridge_pkg;
  localparam logic [11:0] CTRL_OFS   = 12'h000;
  localparam logic [11:0] STAT_OFS   = 12'h004;
  localparam logic [11:0] ADDR_OFS   = 12'h008;
  localparam logic        CTRL_RST   = 1'b1;
  localparam int          SLAVE_DEF  = 127;
  localparam int          BYTES_DEF  = 2;
  localparam int          STEAL_DEF  = 0;
  localparam int          FIFO_DEPTH = 8;
  localparam int          ENTRY_W    = 40;
  localparam int          SYNC_LEN   = 3;

  typedef enum logic [6:0] {
    S_IDLE = 7'h01, S_RX = 7'h02, S_HOLD = 7'h04, S_ACK = 7'h08,
    S_RDWAIT = 7'h10, S_TX = 7'h20, S_MACK = 7'h40
  } ser_state_t;

  typedef enum logic [3:0] {
    B_IDLE = 4'h1, B_WR = 4'h2, B_RD = 4'h4, B_RDATA = 4'h8
  } bus_state_t;
endpackage : bridge_pkg

/* File: i2c_slave_mm_bridge.sv */
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/10ps
// ==========================================================
// write byte queue
module byte_fifo #(
  parameter int WIDTH = 40,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wrPtr_q;
  logic [AW:0]      rdPtr_q;
  wire              push = inValid & inReady;
  wire              pop  = outValid & outReady;

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("fifo depth must be a power of two");
  end

  assign inReady  = !((wrPtr_q[AW] != rdPtr_q[AW]) && (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]));
  assign outValid = wrPtr_q != rdPtr_q;
  assign outData  = mem[rdPtr_q[AW-1:0]];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_q[AW-1:0]] <= inData;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      wrPtr_q <= wrPtr_q + (AW+1)'(push);
      rdPtr_q <= rdPtr_q + (AW+1)'(pop);
    end
  end
endmodule : byte_fifo

// ==========================================================
// bridge top
module i2c_slave_mm_bridge #(
  parameter int SLAVE_ADDR = bridge_pkg::SLAVE_DEF,
  parameter int ADDR_BYTES = bridge_pkg::BYTES_DEF,
  parameter int STEAL_BITS = bridge_pkg::STEAL_DEF,
  parameter bit READ_ONLY  = 1'b0
) (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [31:0] busAddr,
  output logic      [3:0]  busByteEn,
  output logic             busRead,
  input  wire logic [31:0] busRdData,
  input  wire logic        busRdValid,
  input  wire logic        busWait,
  output logic             busWrite,
  output logic      [31:0] busWrData,
  input  wire logic        sdaIn,
  input  wire logic        sclIn,
  output logic             sdaOe,
  output logic             sclOe
);
  import bridge_pkg::*;

  localparam int BYTE_BITS = ADDR_BYTES * 8;
  localparam int USED      = (ADDR_BYTES == 4) ? 32 : BYTE_BITS + STEAL_BITS;
  localparam logic [31:0] USED_MASK  = 32'((64'h1 << USED) - 64'h1);
  localparam logic [31:0] BYTE_MASK  = 32'((64'h1 << BYTE_BITS) - 64'h1);
  localparam logic [31:0] STEAL_MASK = USED_MASK & ~BYTE_MASK;
  localparam logic [6:0]  SLV        = 7'(SLAVE_ADDR);
  localparam logic [2:0]  LAST_IDX   = 3'(ADDR_BYTES + 1);

  if (SLAVE_ADDR < 0 || SLAVE_ADDR > 127 || ADDR_BYTES < 1 || ADDR_BYTES > 4 ||
      STEAL_BITS < 0 || STEAL_BITS > 3) begin : g_chk
    $error("bridge parameter out of range");
  end

  function automatic logic legalBe(input logic [3:0] be);
    return be inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'hF};
  endfunction : legalBe

  // ==========================================================
  // line synchronisers and edge detection
  logic [SYNC_LEN-1:0] sdaSh_q;
  logic [SYNC_LEN-1:0] sclSh_q;
  always_ff @(posedge ref_clk) begin
    sdaSh_q <= {sdaSh_q[SYNC_LEN-2:0], sdaIn};
    sclSh_q <= {sclSh_q[SYNC_LEN-2:0], sclIn};
  end
  wire sdaS     = sdaSh_q[1];
  wire sdaP     = sdaSh_q[2];
  wire sclS     = sclSh_q[1];
  wire sclP     = sclSh_q[2];
  wire startDet = sclS & sclP & sdaP & ~sdaS;
  wire stopDet  = sclS & sclP & ~sdaP & sdaS;
  wire sclRise  = sclS & ~sclP;
  wire sclFall  = ~sclS & sclP;

  // ==========================================================
  // register file
  logic        enable_q;
  logic [31:0] prdata_q;
  ser_state_t  serState_q;
  logic        dirRead_q;
  logic [31:0] addrCnt_q;
  logic        fEmpty;
  wire         hitCtrl = paddr == CTRL_OFS;
  wire         hitStat = paddr == STAT_OFS;
  wire         hitAddr = paddr == ADDR_OFS;
  wire         hitAny  = hitCtrl | hitStat | hitAddr;
  wire         setup   = psel & ~penable;
  wire [31:0]  rdMux   = hitCtrl ? {31'h0, enable_q} :
                         hitStat ? {29'h0, fEmpty, dirRead_q, serState_q != S_IDLE} :
                         hitAddr ? addrCnt_q : 32'h0;
  assign pready  = psel & penable;
  assign pslverr = pready & ~hitAny;
  assign prdata  = prdata_q;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      enable_q <= CTRL_RST;
      prdata_q <= 32'h0;
    end else begin
      if (setup & ~pwrite) prdata_q <= rdMux;
      if (pready & pwrite & hitCtrl) enable_q <= pwdata[0];
    end
  end

  // ==========================================================
  // serial slave
  logic [3:0]  bitCnt_q;
  logic [7:0]  shift_q;
  logic [7:0]  tx_q;
  logic [2:0]  byteIdx_q;
  logic        rdDone;
  logic [7:0]  rdByte;
  logic        fInReady;
  logic        fOutValid;
  logic        fOutReady;
  logic [39:0] fOut;
  wire  match    = enable_q && ((shift_q[7:1] >> STEAL_BITS) == (SLV >> STEAL_BITS));
  wire  isCtrl   = byteIdx_q == 3'h0;
  wire  isAddrB  = !isCtrl && byteIdx_q != LAST_IDX;
  wire  wrPush   = (serState_q == S_HOLD) && !isCtrl && !isAddrB && !READ_ONLY && fInReady;
  wire [31:0] stolen  = 32'(shift_q[3:1]) << BYTE_BITS;
  wire [31:0] addrInc = (addrCnt_q + 32'h1) & USED_MASK;

  assign sclOe = (serState_q == S_HOLD) || (serState_q == S_RDWAIT);
  assign sdaOe = (serState_q == S_ACK) || ((serState_q == S_TX) && !tx_q[7]);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      serState_q <= S_IDLE;
      bitCnt_q   <= 4'h0;
      shift_q    <= 8'h00;
      tx_q       <= 8'hFF;
      byteIdx_q  <= 3'h0;
      dirRead_q  <= 1'b0;
      addrCnt_q  <= 32'h0;
    end else if (startDet) begin
      serState_q <= S_RX;
      bitCnt_q   <= 4'h0;
      byteIdx_q  <= 3'h0;
    end else if (stopDet) begin
      serState_q <= S_IDLE;
    end else begin
      case (serState_q)
        S_RX: begin
          if (sclRise && bitCnt_q != 4'h8) begin
            shift_q  <= {shift_q[6:0], sdaS};
            bitCnt_q <= bitCnt_q + 4'h1;
          end
          if (sclFall && bitCnt_q == 4'h8) serState_q <= S_HOLD;
        end
        S_HOLD: begin
          if (isCtrl) begin
            serState_q <= match ? S_ACK : S_IDLE;
            dirRead_q  <= shift_q[0];
            byteIdx_q  <= (match && !shift_q[0]) ? 3'h1 : 3'h0;
            // stolen bits above the byte address
            if (match) addrCnt_q <= (addrCnt_q & ~STEAL_MASK) | (stolen & STEAL_MASK);
          end else if (isAddrB) begin
            addrCnt_q  <= (addrCnt_q & STEAL_MASK) | ({addrCnt_q[23:0], shift_q} & BYTE_MASK);
            byteIdx_q  <= byteIdx_q + 3'h1;
            serState_q <= S_ACK;
          end else if (READ_ONLY) begin
            serState_q <= S_IDLE;
          end else if (fInReady) begin
            addrCnt_q  <= addrInc;
            serState_q <= S_ACK;
          end
        end
        S_ACK: begin
          if (sclFall) begin
            serState_q <= dirRead_q ? S_RDWAIT : S_RX;
            bitCnt_q   <= 4'h0;
          end
        end
        S_RDWAIT: begin
          if (rdDone) begin
            tx_q       <= rdByte;
            addrCnt_q  <= addrInc;
            bitCnt_q   <= 4'h0;
            serState_q <= S_TX;
          end
        end
        S_TX: begin
          if (sclFall) begin
            tx_q     <= {tx_q[6:0], 1'b1};
            bitCnt_q <= bitCnt_q + 4'h1;
            if (bitCnt_q == 4'h7) serState_q <= S_MACK;
          end
        end
        S_MACK: begin
          if (sclRise && sdaS) serState_q <= S_IDLE;
          else if (sclFall) serState_q <= S_RDWAIT;
        end
        default: serState_q <= S_IDLE;
      endcase
    end
  end

  // ==========================================================
  // bus master with byte merging
  // stalls on a full queue stretch the serial clock instead of dropping bytes
  byte_fifo #(.WIDTH(ENTRY_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk      (ref_clk),
    .rst      (sys_rst),
    .inValid  (wrPush),
    .inReady  (fInReady),
    .inData   ({addrCnt_q, shift_q}),
    .outValid (fOutValid),
    .outReady (fOutReady),
    .outData  (fOut)
  );
  assign fEmpty = !fOutValid;

  bus_state_t  busState_q;
  logic [29:0] accWord_q;
  logic [3:0]  accBe_q;
  logic [31:0] accData_q;
  logic [1:0]  lastLane_q;
  wire  [1:0]  fLane    = fOut[9:8];
  wire  [3:0]  fLaneBit = 4'h1 << fLane;
  wire         wrActive = (serState_q != S_IDLE) && !dirRead_q;
  wire         sameRun  = (accBe_q == 4'h0) || ((fOut[39:10] == accWord_q) &&
                          (fLane == lastLane_q + 2'h1) && !(|(accBe_q & fLaneBit)));
  wire         flushNow = (accBe_q != 4'h0) &&
                          ((fOutValid && !sameRun) || (!fOutValid && !wrActive));
  wire         isBIdle  = busState_q == B_IDLE;
  wire  [3:0]  lowBit   = accBe_q & (~accBe_q + 4'h1);
  wire         rdWant   = serState_q == S_RDWAIT;
  assign fOutReady = isBIdle && !flushNow && fOutValid;
  assign rdDone = (busState_q == B_RDATA) && busRdValid;
  // byte picked by low address bits
  assign rdByte = busRdData[{addrCnt_q[1:0], 3'b000} +: 8];

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      busState_q <= B_IDLE;
      busRead    <= 1'b0;
      busWrite   <= 1'b0;
      busAddr    <= 32'h0;
      busByteEn  <= 4'h0;
      busWrData  <= 32'h0;
      accWord_q  <= 30'h0;
      accBe_q    <= 4'h0;
      accData_q  <= 32'h0;
      lastLane_q <= 2'h0;
    end else begin
      case (busState_q)
        B_IDLE: begin
          if (flushNow) begin
            busWrite   <= !READ_ONLY;
            busByteEn  <= legalBe(accBe_q) ? accBe_q : lowBit;
            accBe_q    <= legalBe(accBe_q) ? 4'h0 : accBe_q & ~lowBit;
            busWrData  <= accData_q;
            busAddr    <= {accWord_q, 2'b00};
            busState_q <= B_WR;
          end else if (fOutValid) begin
            accBe_q    <= accBe_q | fLaneBit;
            accData_q[{fLane, 3'b000} +: 8] <= fOut[7:0];
            accWord_q  <= fOut[39:10];
            lastLane_q <= fLane;
          end else if (rdWant && accBe_q == 4'h0) begin
            busRead    <= 1'b1;
            busAddr    <= {addrCnt_q[31:2], 2'b00};
            busByteEn  <= 4'hF;
            busState_q <= B_RD;
          end
        end
        B_WR: begin
          if (!busWait) begin
            busWrite   <= 1'b0;
            busState_q <= B_IDLE;
          end
        end
        B_RD: begin
          if (!busWait) begin
            busRead    <= 1'b0;
            busState_q <= B_RDATA;
          end
        end
        B_RDATA: begin
          if (busRdValid) busState_q <= B_IDLE;
        end
        default: busState_q <= B_IDLE;
      endcase
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence s_ack_entry;
    (serState_q == S_HOLD) ##1 (serState_q == S_ACK);
  endsequence
  sequence s_ctrl_miss;
    (serState_q == S_HOLD) && isCtrl && !match && !startDet && !stopDet;
  endsequence

  property p_addr_match;
    s_ctrl_miss |=> serState_q == S_IDLE;
  endproperty
  a_addr_match: assert property (p_addr_match) else $error("unmatched address acked");
  property p_addr_byte;
    (serState_q == S_HOLD) && isAddrB && !startDet && !stopDet
      |=> addrCnt_q[7:0] == $past(shift_q);
  endproperty
  a_addr_byte: assert property (p_addr_byte) else $error("address byte not loaded");
  property p_wrap;
    (addrCnt_q & ~USED_MASK) == 32'h0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter beyond address span");
  property p_ro;
    READ_ONLY |-> !busWrite;
  endproperty
  a_ro: assert property (p_ro) else $error("write in read-only build");
  property p_hold;
    (busRead || busWrite) && busWait |=> $stable(busAddr) && $stable(busByteEn) &&
      $stable(busWrData) && $stable(busRead) && $stable(busWrite);
  endproperty
  a_hold: assert property (p_hold) else $error("request moved under wait");
  property p_align;
    (busRead || busWrite) |-> busAddr[1:0] == 2'b00;
  endproperty
  a_align: assert property (p_align) else $error("unaligned bus address");
  property p_legal;
    busWrite |-> legalBe(busByteEn);
  endproperty
  a_legal: assert property (p_legal) else $error("illegal byte enables");
  property p_read_pulse;
    $rose(busRead) && !busWait |=> !busRead ##1 !busRead;
  endproperty
  a_read_pulse: assert property (p_read_pulse) else $error("read longer than one cycle");
  property p_ack_drive;
    s_ack_entry |-> sdaOe && !sclOe;
  endproperty
  a_ack_drive: assert property (p_ack_drive) else $error("ack not driven");
  property p_reset;
    disable iff (1'b0) sys_rst |=> !busRead && !busWrite && serState_q == S_IDLE;
  endproperty
  a_reset: assert property (p_reset) else $error("reset left activity");
endmodule : i2c_slave_mm_bridge

/* File: mm_slave_model.sv */
`timescale 1ns/10ps
// ==========================================================
// memory-mapped slave, prompt or stalling
module mm_slave_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        stall,
  input  wire logic [31:0] busAddr,
  input  wire logic [3:0]  busByteEn,
  input  wire logic        busRead,
  input  wire logic        busWrite,
  input  wire logic [31:0] busWrData,
  output logic      [31:0] busRdData,
  output logic             busRdValid,
  output logic             busWait,
  output int               badCount
);
  logic [31:0] mem [0:16383];
  logic [31:0] lastData;
  logic [69:0] snap;
  logic [13:0] rdIdx;
  logic [1:0]  waitCnt, rdDelay;
  logic        req, prevWait, unstable, badBe, badAddr;
  assign req = busRead | busWrite;
  assign busWait = stall & req & (waitCnt != 2'h0);
  // word only with its strobe; otherwise a changing value
  assign busRdData = busRdValid ? mem[rdIdx] : ~lastData;
  assign unstable = prevWait & (snap !== {busAddr, busByteEn, busRead, busWrite, busWrData});
  assign badBe = busWrite & ~busWait & !(busByteEn inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'hF});
  // aligned and inside the 16-bit space
  assign badAddr = req & ((busAddr[1:0] != 2'h0) | (busAddr[31:16] != 16'h0));
  initial begin
    for (int a = 0; a < 65536; a++) mem[a/4][8*(a%4)+:8] = 8'(a) ^ 8'h5A;
  end
  always @(posedge clk) begin
    prevWait <= busWait & ~rst;
    snap <= {busAddr, busByteEn, busRead, busWrite, busWrData};
    if (rst) begin
      waitCnt <= 2'h3;
      rdDelay <= 2'h0;
      busRdValid <= 1'b0;
      badCount <= 0;
      lastData <= 32'h0;
    end else begin
      waitCnt <= !req ? 2'h3 : (waitCnt == 2'h0 ? 2'h0 : waitCnt - 2'h1);
      busRdValid <= (rdDelay == 2'h1);
      rdDelay <= (busRead & ~busWait) ? 2'h2 : (rdDelay == 2'h0 ? 2'h0 : rdDelay - 2'h1);
      badCount <= badCount + int'(unstable) + int'(badBe) + int'(badAddr);
      if (busRdValid) lastData <= mem[rdIdx];
      if (busRead & ~busWait) rdIdx <= busAddr[15:2];
      if (busWrite & ~busWait) begin
        for (int k = 0; k < 4; k++) begin
          if (busByteEn[k]) mem[busAddr[15:2]][8*k+:8] <= busWrData[8*k+:8];
        end
      end
    end
  end
endmodule : mm_slave_model

/* File: test_i2c_slave_mm_bridge.sv */
`timescale 1ns/10ps
module test_i2c_slave_mm_bridge;
  import bridge_pkg::*;
  typedef struct packed {logic [15:0] addr; logic [3:0] len; logic [7:0] d0;} row_t;
  localparam logic [6:0] SLV   = 7'(SLAVE_DEF);
  localparam int         LIMIT = 60000;
  logic        ref_clk, sys_rst, psel, penable, pwrite, stall, mSclLow, mSdaLow;
  logic        pready, pslverr, busRead, busWrite, busRdValid, busWait;
  logic        sdaOe, sclOe, sdaLine, sclLine, ack, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, busAddr, busWrData, busRdData, d;
  logic [3:0]  busByteEn;
  logic [7:0]  q;
  logic [7:0]  shadow [0:65535];
  int          nErrors, cmpCount, cycles, badCount;
  row_t        rows [6] = '{'{16'h0004, 4'h2, 8'h11}, '{16'h0010, 4'h3, 8'h21},
                           '{16'h0020, 4'h4, 8'h31}, '{16'h0033, 4'h1, 8'h41},
                           '{16'h0045, 4'h6, 8'h51}, '{16'hFFFF, 4'h2, 8'h61}};
  // pulled-up lines: low while any party pulls
  assign sdaLine = ~(sdaOe | mSdaLow);
  assign sclLine = ~(sclOe | mSclLow);
  i2c_slave_mm_bridge u_i2c_slave_mm_bridge (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .busAddr(busAddr),
    .busByteEn(busByteEn), .busRead(busRead), .busRdData(busRdData),
    .busRdValid(busRdValid), .busWait(busWait), .busWrite(busWrite),
    .busWrData(busWrData), .sdaIn(sdaLine), .sclIn(sclLine), .sdaOe(sdaOe), .sclOe(sclOe));
  mm_slave_model u_mm_slave_model (.clk(ref_clk), .rst(sys_rst), .stall(stall),
    .busAddr(busAddr), .busByteEn(busByteEn), .busRead(busRead), .busWrite(busWrite),
    .busWrData(busWrData), .busRdData(busRdData), .busRdValid(busRdValid),
    .busWait(busWait), .badCount(badCount));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // ==========================================================
  // helpers
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmpCount, nErrors);
    if (nErrors == 0 && cmpCount > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input bit ok, input string msg);
    cmpCount++;
    if (!ok) begin
      nErrors++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] w);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= w;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    d = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle cycle so a following call never re-drives psel in this time step
    @(posedge ref_clk);
  endtask : apb
  task automatic sbit(input logic b, output logic r);
    cyc(1);
    mSdaLow <= ~b;
    cyc(4);
    mSclLow <= 1'b0;
    cyc(1);
    // slave may stretch the clock
    while (sclLine !== 1'b1) cyc(1);
    cyc(4);
    r = sdaLine;
    mSclLow <= 1'b1;
  endtask : sbit
  task automatic sbyte(input logic [7:0] w, input logic mAck);
    for (int i = 7; i >= 0; i--) sbit(w[i], q[i]);
    sbit(mAck, ack);
  endtask : sbyte
  task automatic start();
    cyc(1);
    mSdaLow <= 1'b0;
    cyc(2);
    mSclLow <= 1'b0;
    while (sclLine !== 1'b1) cyc(1);
    cyc(4);
    mSdaLow <= 1'b1;
    cyc(4);
    mSclLow <= 1'b1;
  endtask : start
  task automatic stop();
    cyc(1);
    mSdaLow <= 1'b1;
    cyc(4);
    mSclLow <= 1'b0;
    while (sclLine !== 1'b1) cyc(1);
    cyc(4);
    mSdaLow <= 1'b0;
    cyc(40);
  endtask : stop
  task automatic hdr(input logic [15:0] a);
    start();
    sbyte({SLV, 1'b0}, 1'b1);
    sbyte(a[15:8], 1'b1);
    sbyte(a[7:0], 1'b1);
  endtask : hdr
  task automatic wr(input logic [15:0] a, input int n, input logic [7:0] d0);
    hdr(a);
    for (int i = 0; i < n; i++) begin
      sbyte(d0 + 8'(i), 1'b1);
      chk(ack === 1'b0, "data byte not acked");
      shadow[16'(a + i)] = d0 + 8'(i);
    end
    stop();
  endtask : wr
  task automatic rd(input logic [15:0] a, input int n);
    hdr(a);
    start();
    sbyte({SLV, 1'b1}, 1'b1);
    for (int i = 0; i < n; i++) begin
      sbyte(8'hFF, i == n - 1);
      chk(q === shadow[16'(a + i)], "read byte mismatch");
    end
    stop();
  endtask : rd
  // ==========================================================
  // timeout
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      chk(1'b0, "timeout");
      stop_test();
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    {sys_rst, psel, penable, pwrite, stall, mSclLow, mSdaLow} = 7'h40;
    {paddr, pwdata, nErrors, cmpCount, cycles} = '0;
    for (int a = 0; a < 65536; a++) shadow[a] = 8'(a) ^ 8'h5A;
    cyc(8);
    sys_rst <= 1'b0;
    cyc(4);
    foreach (rows[r]) begin
      wr(rows[r].addr, int'(rows[r].len), rows[r].d0);
      rd(rows[r].addr, int'(rows[r].len) + 1);
      $display("row %0d done", r);
    end
    start();
    sbyte({SLV, 1'b1}, 1'b1);
    sbyte(8'hFF, 1'b1);
    chk(q === shadow[16'h0002], "current address read");
    stop();
    $display("current address read done");
    sys_rst <= 1'b1;
    cyc(3);
    chk({busRead, busWrite, sdaOe, sclOe, busAddr} === 36'h0, "outputs not idle");
    sys_rst <= 1'b0;
    cyc(4);
    start();
    sbyte({7'h12, 1'b0}, 1'b1);
    chk(ack === 1'b1, "foreign address acked");
    stop();
    apb(1'b0, CTRL_OFS, 32'h0);
    chk(d === 32'h1 && err === 1'b0, "enable reset value");
    apb(1'b0, 12'h0FC, 32'h0);
    chk(err === 1'b1 && d === 32'h0, "unmapped offset");
    apb(1'b1, CTRL_OFS, 32'h0);
    start();
    sbyte({SLV, 1'b0}, 1'b1);
    chk(ack === 1'b1, "disabled bridge acked");
    stop();
    apb(1'b1, CTRL_OFS, 32'h1);
    $display("reset and control done");
    stall <= 1'b1;
    wr(16'h0101, 3, 8'h71);
    rd(16'h0100, 5);
    stall <= 1'b0;
    cyc(4);
    chk(badCount === 0, "bus protocol fault seen by slave");
    $display("stall test done");
    stop_test();
  end
endmodule : test_i2c_slave_mm_bridge
